// ### include/rco_pkg.sv
// Constants and field layout for the reference clock output block.
package rco_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [11:0] CONTROL_IDX    = 12'h895;
  localparam logic [11:0] SOURCE_SEL_IDX = 12'h896;
  localparam logic [11:0] STATUS_IDX     = 12'h897;
  localparam int          ADDR_SHIFT     = 2;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         CTRL_EN_BIT   = 7;
  localparam int         CTRL_DUTY_LSB = 3;
  localparam int         CTRL_DIV_LSB  = 0;
  localparam int         SEL_LSB       = 0;
  localparam logic       EN_RESET      = 1'b0;
  localparam logic [1:0] DUTY_RESET    = 2'h2;
  localparam logic [2:0] DIV_RESET     = 3'h0;
  localparam logic [3:0] SEL_RESET     = 4'h0;
  localparam int         STAT_RUN_BIT  = 0;
  localparam int         STAT_OUT_BIT  = 1;

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  // Code 0 is the system clock, codes 1 to 10 the other sources in order.
  localparam int         NUM_SOURCES   = 11;
  localparam logic [3:0] SRC_SYSCLK    = 4'h0;
  localparam logic [3:0] SRC_LAST      = 4'hA;

  // ----------------------------------------------------------------
  // Bus encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;

endpackage : rco_pkg

// ### logic/rco_top.sv
// Reference clock output block with its AHB-Lite register slave.
//
// Notes on behaviour
// - Setting the enable starts the output glitch-free with whole periods.
// - Clearing the enable shuts the output off at once, without finishing the period.
// - The selected source is divided by a power of two from 1 (pass-through) to 128.
// - Except at pass-through the duty is 0, 25, 50 or 75 percent by the duty field.
// - At pass-through the duty is 50 percent for every duty code except zero, which holds low.
// - The duty field resets to binary 10, giving 50 percent by default.
// - In sleep the output keeps running for every source except code zero, the system clock.
// - The input clock is chosen by the 4-bit field in bits 3 to 0 of source select.
// - The shaped signal also goes to other peripherals as an internal clock.
// - The enable sits in bit 7 of the control register and resets to 0.
// - Source codes 0 to 10 map to the system clock through logic cell 4; higher are reserved.
// - Divider codes 0 to 7 give ratios 1, 2, 4, 8, 16, 32, 64 and 128.
// - Duty codes 0 to 3 give 0, 25, 50 and 75 percent.
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps

module rco_top (
  input  wire logic        hclk,            // Bus and sampling clock, 20 MHz.
  input  wire logic        hresetn,         // Asynchronous reset, active low.
  input  wire logic        hsel,            // Slave select.
  input  wire logic [31:0] haddr,           // Byte address.
  input  wire logic [1:0]  htrans,          // Transfer type.
  input  wire logic        hwrite,          // Write when high.
  input  wire logic [2:0]  hsize,           // Transfer size, word only.
  input  wire logic [31:0] hwdata,          // Write data.
  input  wire logic        hready,          // Bus ready.
  output logic      [31:0] hrdata,          // Read data.
  output logic             hreadyout,       // Slave ready, always high.
  output logic             hresp,           // Response, always OKAY.
  input  wire logic [10:0] src_clk,         // Candidate source clocks, one bit per code.
  input  wire logic        sleep_mode,      // Device is asleep; the system clock stops.
  output logic             ref_clock_out_pin, // Shaped reference to the pin.
  output logic             ref_clock_int    // Same signal routed to peripherals.
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [10:0] sync1;      // First synchroniser stage.
    logic [10:0] sync2;      // Second synchroniser stage.
    logic        prev_lvl;   // Selected source level one cycle ago.
    logic        en;         // Module enable.
    logic [1:0]  duty;       // Duty select.
    logic [2:0]  div;        // Divider select.
    logic [3:0]  sel;        // Source select.
    logic        run;        // Output running.
    logic [7:0]  cnt;        // Half-period counter.
    logic        out;        // Shaped output.
    logic        ph_wr;      // Pending write data phase.
    logic [11:0] ph_idx;     // Register index of pending write.
    logic [31:0] rdata;      // Read data register.
  } rco_state_t;

  rco_state_t st_q;
  rco_state_t st_d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Duty threshold in half-periods: duty quarters of 2N half-periods.
  function automatic logic [9:0] rco_thresh(input logic [1:0] duty, input logic [2:0] div);
    logic [9:0] t;
    t = 10'(duty) << div;
    return t >> 1;
  endfunction : rco_thresh

  // Mask for wrapping the half-period counter at 2N.
  function automatic logic [7:0] rco_mask(input logic [2:0] div);
    logic [8:0] m;
    // The shift amount is widened so that ratio 128 does not wrap to a zero mask.
    m = (9'h001 << ({1'b0, div} + 4'h1)) - 9'h001;
    return m[7:0];
  endfunction : rco_mask

  // Level output for a given phase and settings.
  function automatic logic rco_shape(input logic [7:0] cnt, input logic [1:0] duty,
                                     input logic [2:0] div, input logic lvl);
    if (div == 3'h0) begin
      return (duty != 2'h0) && lvl;
    end
    return 10'(cnt) < rco_thresh(duty, div);
  endfunction : rco_shape

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  logic       src_lvl;
  logic       src_edge;
  logic       src_rise;
  logic [7:0] cnt_next;
  logic       bus_req;
  logic [11:0] req_idx;

  // Pick the synchronised source; reserved codes and a sleeping system clock give no edges.
  always_comb begin
    if (st_q.sel > rco_pkg::SRC_LAST) begin
      src_lvl = 1'b0;
    end else if (sleep_mode && st_q.sel == rco_pkg::SRC_SYSCLK) begin
      src_lvl = 1'b0;
    end else begin
      src_lvl = st_q.sync2[st_q.sel];
    end
  end

  assign src_edge = src_lvl != st_q.prev_lvl;
  assign src_rise = src_lvl && !st_q.prev_lvl;
  assign cnt_next = (st_q.cnt + 8'h01) & rco_mask(st_q.div);
  assign bus_req  = hsel && hready && (htrans == rco_pkg::HTRANS_NONSEQ ||
                                       htrans == rco_pkg::HTRANS_SEQ);
  assign req_idx  = haddr[rco_pkg::ADDR_SHIFT +: 12];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Synchronise sources, serve the bus and advance the divider.
  always_comb begin
    st_d          = st_q;
    st_d.sync1    = src_clk;
    st_d.sync2    = st_q.sync1;
    st_d.prev_lvl = src_lvl;

    // Write data phase lands in the registers.
    st_d.ph_wr = 1'b0;
    if (st_q.ph_wr) begin
      if (st_q.ph_idx == rco_pkg::CONTROL_IDX) begin
        st_d.en   = hwdata[rco_pkg::CTRL_EN_BIT];
        st_d.duty = hwdata[rco_pkg::CTRL_DUTY_LSB +: 2];
        st_d.div  = hwdata[rco_pkg::CTRL_DIV_LSB +: 3];
      end else if (st_q.ph_idx == rco_pkg::SOURCE_SEL_IDX) begin
        st_d.sel = hwdata[rco_pkg::SEL_LSB +: 4];
      end
    end

    // Address phase: latch a write or prepare read data.
    if (bus_req) begin
      st_d.ph_wr  = hwrite;
      st_d.ph_idx = req_idx;
      st_d.rdata  = 32'h0000_0000;
      if (!hwrite) begin
        unique case (req_idx)
          rco_pkg::CONTROL_IDX: begin
            st_d.rdata[rco_pkg::CTRL_EN_BIT]        = st_q.en;
            st_d.rdata[rco_pkg::CTRL_DUTY_LSB +: 2] = st_q.duty;
            st_d.rdata[rco_pkg::CTRL_DIV_LSB +: 3]  = st_q.div;
          end
          rco_pkg::SOURCE_SEL_IDX: begin
            st_d.rdata[rco_pkg::SEL_LSB +: 4] = st_q.sel;
          end
          rco_pkg::STATUS_IDX: begin
            st_d.rdata[rco_pkg::STAT_RUN_BIT] = st_q.run;
            st_d.rdata[rco_pkg::STAT_OUT_BIT] = st_q.out;
          end
          default: begin
            st_d.rdata = 32'h0000_0000;
          end
        endcase
      end
    end

    // Divider and shaper, stepping only on sampled source edges.
    if (!st_q.en) begin
      st_d.run = 1'b0;
      st_d.cnt = 8'h00;
      st_d.out = 1'b0;
    end else if (!st_q.run) begin
      if (src_rise) begin
        st_d.run = 1'b1;
        st_d.cnt = 8'h00;
        st_d.out = rco_shape(8'h00, st_q.duty, st_q.div, src_lvl);
      end
    end else if (src_edge || st_q.div == 3'h0) begin
      if (src_edge) begin
        st_d.cnt = cnt_next;
      end
      st_d.out = rco_shape(src_edge ? cnt_next : st_q.cnt, st_q.duty, st_q.div, src_lvl);
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Register the state; reset gives the documented control defaults.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q          <= '0;
      st_q.en       <= rco_pkg::EN_RESET;
      st_q.duty     <= rco_pkg::DUTY_RESET;
      st_q.div      <= rco_pkg::DIV_RESET;
      st_q.sel      <= rco_pkg::SEL_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Zero-wait, always-OKAY slave; the shaped signal goes both out and inward.
  assign hrdata            = st_q.rdata;
  assign hreadyout         = 1'b1;
  assign hresp             = 1'b0;
  assign ref_clock_out_pin = st_q.out;
  assign ref_clock_int     = st_q.out;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // A cleared enable forces the output low on the next edge.
  off_at_once_a: assert property (
    !st_q.en |=> !st_q.out && !st_q.run && st_q.cnt == 8'h00)
    else $error("Output not off after disable.");

  // The output never rises unless the module is running.
  out_needs_run_a: assert property (st_q.out |-> st_q.run)
    else $error("Output high while not running.");

  // The start happens exactly on a source rising edge.
  clean_start_a: assert property (
    st_q.en && !st_q.run && src_rise |=> st_q.run && st_q.cnt == 8'h00)
    else $error("Start not aligned to source rise.");

  // Without a rising edge the module does not start.
  no_early_start_a: assert property (st_q.en && !st_q.run && !src_rise |=> !st_q.run)
    else $error("Start without source edge.");

  // A zero duty code keeps a running output low.
  zero_duty_low_a: assert property (st_q.out |-> $past(st_q.duty) != 2'h0)
    else $error("Output high with zero duty.");

  // Pass-through follows the source level one cycle later.
  pass_through_a: assert property (st_q.run && st_q.en && st_q.div == 3'h0 && st_q.duty != 2'h0
                                   |=> st_q.out == $past(src_lvl))
    else $error("Pass-through does not follow source.");

  // The half-period counter stays within twice the ratio.
  count_bound_a: assert property (st_q.cnt <= rco_mask($past(st_q.div)))
    else $error("Divider counter out of range.");

  // Divided output matches the duty threshold on each counted edge.
  duty_shape_a: assert property (
    st_q.run && st_q.en && st_q.div != 3'h0 && src_edge
    |=> st_q.out == (10'(st_q.cnt) < rco_thresh($past(st_q.duty), $past(st_q.div))))
    else $error("Divided output has wrong duty.");

  // A sleeping system clock source gives no edges.
  sleep_sys_a: assert property (
    sleep_mode && st_q.sel == rco_pkg::SRC_SYSCLK |-> !src_lvl)
    else $error("System clock source active in sleep.");

  // Reserved source codes give no edges.
  reserved_src_a: assert property (st_q.sel > rco_pkg::SRC_LAST |-> !src_lvl)
    else $error("Reserved source produced a level.");

  // ----------------------------------------------------------------
  // Register and divider assertions
  // ----------------------------------------------------------------

  // A control write lands all three fields at the end of its data phase.
  ctrl_write_a: assert property (
    st_q.ph_wr && st_q.ph_idx == rco_pkg::CONTROL_IDX
    |=> {st_q.en, st_q.duty, st_q.div} == $past({hwdata[rco_pkg::CTRL_EN_BIT],
        hwdata[rco_pkg::CTRL_DUTY_LSB +: 2], hwdata[rco_pkg::CTRL_DIV_LSB +: 3]}))
    else $error("Control write did not land.");

  // A source-select write lands its four code bits.
  sel_write_a: assert property (
    st_q.ph_wr && st_q.ph_idx == rco_pkg::SOURCE_SEL_IDX
    |=> st_q.sel == $past(hwdata[rco_pkg::SEL_LSB +: 4]))
    else $error("Source select write did not land.");

  // Without a write to a mapped register the settings keep their values.
  settings_kept_a: assert property (
    !(st_q.ph_wr && (st_q.ph_idx == rco_pkg::CONTROL_IDX ||
                     st_q.ph_idx == rco_pkg::SOURCE_SEL_IDX))
    |=> $stable({st_q.en, st_q.duty, st_q.div, st_q.sel}))
    else $error("Settings changed without a write.");

  // A control read returns the fields as they stood at the address phase.
  ctrl_read_a: assert property (
    bus_req && !hwrite && req_idx == rco_pkg::CONTROL_IDX
    |=> hrdata[rco_pkg::CTRL_EN_BIT] == $past(st_q.en)
        && hrdata[rco_pkg::CTRL_DUTY_LSB +: 2] == $past(st_q.duty)
        && hrdata[rco_pkg::CTRL_DIV_LSB +: 3] == $past(st_q.div))
    else $error("Control read data wrong.");

  // A source-select read returns the code as it stood at the address phase.
  sel_read_a: assert property (
    bus_req && !hwrite && req_idx == rco_pkg::SOURCE_SEL_IDX
    |=> hrdata[rco_pkg::SEL_LSB +: 4] == $past(st_q.sel))
    else $error("Source select read data wrong.");

  // The divider only runs in the cycle after an enable was seen.
  run_needs_en_a: assert property (st_q.run |-> $past(st_q.en))
    else $error("Divider running without enable.");

  // A divided output only moves on a sampled source edge.
  hold_between_a: assert property (
    st_q.en && st_q.run && st_q.div != 3'h0 && !src_edge
    |=> st_q.out == $past(st_q.out))
    else $error("Divided output moved between source edges.");

  // Pass-through with the zero duty code keeps the output low.
  pass_zero_low_a: assert property (
    st_q.div == 3'h0 && st_q.duty == 2'h0 |=> !st_q.out)
    else $error("Pass-through high with zero duty.");

  // The half-period counter wraps to zero after its last count.
  count_wrap_a: assert property (
    st_q.en && st_q.run && src_edge && st_q.cnt == rco_mask(st_q.div)
    |=> st_q.cnt == 8'h00)
    else $error("Divider counter did not wrap.");

  // A divided output with non-zero duty begins with its high phase.
  start_high_a: assert property (
    st_q.en && !st_q.run && src_rise && st_q.div != 3'h0 && st_q.duty != 2'h0
    |=> st_q.out)
    else $error("Start did not begin with a high phase.");

endmodule : rco_top

// ### sim/rco_src_model.sv
// Source clock model standing in for the oscillators and logic cells.
`timescale 1ns/1ps

module rco_src_model (
  hclk,    // Sampling clock, 20 MHz.
  src_clk  // One free-running source per source code.
);
  input  wire logic        hclk;
  output logic      [10:0] src_clk;

  logic        [10:0] lvl_q = 11'h000;
  int unsigned        cnt_q [11] = '{default: 0};

  // ----------------------------------------------------------------
  // Source generation
  // ----------------------------------------------------------------
  // Source n toggles every 4+2n cycles, so each code has its own rate.
  assign src_clk = lvl_q;

  // Toggling on the sampling edge keeps every source period a whole count.
  always @(posedge hclk) begin
    for (int n = 0; n < 11; n++) begin
      if (cnt_q[n] >= 3 + 2 * n) begin
        cnt_q[n] <= 0;
        lvl_q[n] <= ~lvl_q[n];
      end else begin
        cnt_q[n] <= cnt_q[n] + 1;
      end
    end
  end
endmodule : rco_src_model

// ### sim/rco_tb_top.sv
// Self-checking testbench for the reference clock output block.
`timescale 1ns/1ps

module rco_tb_top;
  localparam logic [11:0] CTL = rco_pkg::CONTROL_IDX;
  localparam logic [11:0] SEL = rco_pkg::SOURCE_SEL_IDX;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [10:0] src_clk;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        sleep_mode, pin, pin_int, v;
  int          failures, n_checks;

  assign hready = hreadyout;
  rco_src_model rco_src_model_inst (.hclk(hclk), .src_clk(src_clk));
  rco_top rco_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .src_clk(src_clk),
    .sleep_mode(sleep_mode), .ref_clock_out_pin(pin), .ref_clock_int(pin_int));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Prints the verdict and ends the run.
  task automatic complete_run();
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check

  // One single transfer; entered just after a rising edge.
  task automatic bus(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {18'h00000, idx, 2'h0};
    htrans <= rco_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
    @(posedge hclk);
  endtask : bus

  // Settings are written while disabled, then the enable is set.
  task automatic run(input logic [3:0] s, input logic [2:0] dv, input logic [1:0] dt);
    bus(1'b1, CTL, {27'h0000000, dt, dv});
    bus(1'b1, SEL, {28'h0000000, s});
    bus(1'b1, CTL, {24'h000000, 1'b1, 2'h0, dt, dv});
  endtask : run

  // Times the first whole period after the output leaves low.
  task automatic measure(input int per, input int hi);
    int h, p;
    h = 0;
    p = 0;
    while (pin !== 1'b0 && p < 9000) begin @(negedge hclk); p++; end
    while (pin !== 1'b1 && p < 9000) begin @(negedge hclk); p++; end
    while (pin === 1'b1 && h < 9000) begin
      @(negedge hclk);
      h++;
      check(pin_int === pin, "internal copy differs");
    end
    p = h;
    while (pin === 1'b0 && p < 9000) begin @(negedge hclk); p++; end
    check(h == hi, "high time");
    check(p == per, "period");
    @(posedge hclk);
  endtask : measure

  task automatic hold_low(input int n);
    repeat (n) begin @(negedge hclk); check(pin === 1'b0, "output not low"); end
    @(posedge hclk);
  endtask : hold_low

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    check(pin === 1'b0, "output after reset");
    bus(1'b0, CTL, 32'h00000000);
    check(rd === 32'h00000010, "control reset");
    bus(1'b0, SEL, 32'h00000000);
    check(rd === 32'h00000000, "select reset");
    bus(1'b0, 12'h894, 32'h00000000);
    check(rd === 32'h00000000, "unmapped read");
    bus(1'b1, SEL, 32'h000000A5);
    bus(1'b0, SEL, 32'h00000000);
    check(rd === 32'h00000005, "select field");
    bus(1'b1, CTL, 32'h0000001F);
    bus(1'b0, CTL, 32'h00000000);
    check(rd === 32'h0000001F, "control fields");
  endtask : t_regs

  task automatic t_shape();
    for (int dv = 1; dv <= 2; dv++) begin
      for (int dt = 1; dt <= 3; dt++) begin
        run(4'h3, dv[2:0], dt[1:0]);
        measure(20 << dv, (20 << dv) * dt / 4);
        bus(1'b1, CTL, 32'h00000000);
      end
    end
    run(4'h3, 3'h1, 2'h0);
    hold_low(200);
    run(4'h1, 3'h7, 2'h2);
    measure(1536, 768);
  endtask : t_shape

  task automatic t_pass();
    run(4'h3, 3'h0, 2'h1);
    measure(20, 10);
    run(4'h3, 3'h0, 2'h3);
    measure(20, 10);
    run(4'h3, 3'h0, 2'h0);
    hold_low(100);
    run(4'hB, 3'h1, 2'h2);
    hold_low(100);
  endtask : t_pass

  task automatic t_off();
    run(4'h3, 3'h3, 2'h3);
    while (pin !== 1'b1) @(posedge hclk);
    bus(1'b0, rco_pkg::STATUS_IDX, 32'h00000000);
    check(rd === 32'h00000003, "status while running");
    bus(1'b1, CTL, 32'h0000001B);
    @(negedge hclk);
    check(pin === 1'b0, "disable not immediate");
    hold_low(200);
    bus(1'b0, rco_pkg::STATUS_IDX, 32'h00000000);
    check(rd === 32'h00000000, "status after disable");
  endtask : t_off

  task automatic t_sleep();
    run(4'h0, 3'h1, 2'h2);
    measure(16, 8);
    @(posedge hclk);
    sleep_mode <= 1'b1;
    repeat (10) @(negedge hclk);
    v = pin;
    repeat (100) begin @(negedge hclk); check(pin === v, "output moved"); end
    @(posedge hclk);
    bus(1'b1, CTL, 32'h00000000);
    run(4'h3, 3'h1, 2'h2);
    measure(40, 20);
    @(posedge hclk);
    sleep_mode <= 1'b0;
  endtask : t_sleep

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // The tests need about 3000 cycles; 60000 means a hang.
  initial begin
    #3000000;
    failures++;
    complete_run();
  end

  initial begin
    failures = 0;
    n_checks = 0;
    {hresetn, hsel, hwrite, sleep_mode} = 4'h0;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    htrans = 2'h0;
    hsize = 3'h2;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_shape();
    t_pass();
    t_off();
    t_sleep();
    complete_run();
  end
endmodule : rco_tb_top
